// >>> inc/tfp_pkg.sv
// constants and types for the thermal fan pwm controller
package tfp_pkg;

  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CONV_TIME_MS = 120;
  localparam int unsigned SPINUP_TIME_MS = 2000;
  localparam int unsigned CONV_CYCLES = CLK_HZ / 1000 * CONV_TIME_MS;
  localparam int unsigned SPINUP_CYCLES = CLK_HZ / 1000 * SPINUP_TIME_MS;
  localparam int unsigned PWM_DIV_SLOW = 31565;
  localparam int CONV_CNT_W = 25;
  localparam int SPIN_CNT_W = 29;
  localparam int PWM_DIV_W = 15;

  // register offsets
  localparam logic [7:0] ADDR_TEMP1 = 8'h00;
  localparam logic [7:0] ADDR_TEMP2 = 8'h01;
  localparam logic [7:0] ADDR_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_OT_LIM1 = 8'h03;
  localparam logic [7:0] ADDR_OT_LIM2 = 8'h04;
  localparam logic [7:0] ADDR_OT_STATUS = 8'h05;
  localparam logic [7:0] ADDR_OT_MASK = 8'h06;
  localparam logic [7:0] ADDR_START_DUTY1 = 8'h07;
  localparam logic [7:0] ADDR_START_DUTY2 = 8'h08;
  localparam logic [7:0] ADDR_MAX_DUTY1 = 8'h09;
  localparam logic [7:0] ADDR_MAX_DUTY2 = 8'h0A;
  localparam logic [7:0] ADDR_TARGET1 = 8'h0B;
  localparam logic [7:0] ADDR_TARGET2 = 8'h0C;
  localparam logic [7:0] ADDR_STEP_CFG = 8'h0D;
  localparam logic [7:0] ADDR_START_TEMP1 = 8'h0F;
  localparam logic [7:0] ADDR_START_TEMP2 = 8'h10;
  localparam logic [7:0] ADDR_CHAN_SEL = 8'h11;
  localparam logic [7:0] ADDR_RATE = 8'h12;
  localparam logic [7:0] ADDR_FREQ_SEL = 8'h13;
  localparam logic [7:0] ADDR_DUTY_NOW1 = 8'h14;
  localparam logic [7:0] ADDR_DUTY_NOW2 = 8'h15;
  localparam logic [7:0] ADDR_THERM_OFS = 8'h17;
  localparam logic [7:0] ADDR_TEMP_LOW = 8'h1E;

  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h18;
  localparam logic [7:0] RST_OT_LIM1 = 8'h6E;
  localparam logic [7:0] RST_OT_LIM2 = 8'h50;
  localparam logic [7:0] RST_MAX_DUTY = 8'hF0;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // field positions
  localparam int CFG_INVERT = 4;
  localparam int CFG_MIN_DUTY = 3;
  localparam int CFG_SPIN_DIS = 2;
  localparam int CFG_LOCAL2 = 5;
  localparam int STEP_HYST = 7;
  localparam int STEP_TSTEP = 6;
  localparam int STAT_CH1 = 7;
  localparam int STAT_CH2 = 6;

  localparam logic [7:0] DUTY_FULL = 8'hF0;
  localparam logic [7:0] PWM_LAST = 8'hEF;
  localparam logic [7:0] PEAK_DROP = 8'h05;
  localparam logic [7:0] HYST_SMALL = 8'h05;
  localparam logic [7:0] HYST_LARGE = 8'h0A;
  localparam logic [7:0] DUTY_STEP = 8'h02;
  localparam logic [1:0] SEL_MANUAL = 2'h0;
  localparam logic [1:0] SEL_CH1 = 2'h1;
  localparam logic [1:0] SEL_CH2 = 2'h2;

  typedef enum logic [1:0] {
    TFP_OFF = 2'b00,
    TFP_SPIN = 2'b01,
    TFP_RUN = 2'b11
  } tfp_fan_state_t;

  // pwm step dividers for the faster frequency settings
  function automatic logic [PWM_DIV_W-1:0] tfp_div_lookup(input logic [2:0] sel);
    unique case (sel)
      3'h1: tfp_div_lookup = 15'h0ECC;
      3'h2: tfp_div_lookup = 15'h0766;
      3'h3: tfp_div_lookup = 15'h03B3;
      3'h4: tfp_div_lookup = 15'h01D9;
      3'h5: tfp_div_lookup = 15'h00ED;
      3'h6: tfp_div_lookup = 15'h003B;
      3'h7: tfp_div_lookup = 15'h001E;
      default: tfp_div_lookup = 15'h001E;
    endcase
  endfunction

endpackage

// >>> hw/tfp_fan_ctrl.sv
// two-channel temperature driven fan pwm controller core
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - convert both channels in turn, 120 ms each
// - negative offset, below zero result clips zero
// - local temp unsigned byte plus three fraction bits
// - thermistor result is voltage fraction, 7.68 mV/count
// - over threshold sets flag, unmasked asserts alert
// - masked channel sets flag, alert stays off
// - status read clears flags; mask clears alert
// - fault persisting sets flag again next conversion
// - invert bit in config byte flips pwm sense
// - fan from standstill driven full on 2 s first, pin level set by the invert bit
// - spin-up disabled: jump straight to nominal duty
// - frequency select register sets pwm rate
// - a fan's own select pair zero means manual duty for that fan
// - manual duty clipped to 240, max ignored
// - below start temperature: zero or start duty
// - duty = start duty + excess/step times step size
// - recompute on rise, hold until 5 C drop
// - hysteresis below start temperature, set by bit 7
// - automatic duty clamped to maximum duty register
// - temperature step chosen by one config bit
// - start temperature belongs to channel, not output
// - odd duty rounded down to even
// - duty ramps toward target at rate register pace
// - fault flags in status bits 7 and 6
module tfp_fan_ctrl
  import tfp_pkg::*;
#(
  parameter int unsigned CONV_CNT = CONV_CYCLES,
  parameter int unsigned SPIN_CNT = SPINUP_CYCLES,
  parameter int unsigned PWM_DIV_LOW = PWM_DIV_SLOW
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic signed [11:0] adc_result,
  output logic conv_start,
  output logic conv_channel,
  output logic conv_local,
  output logic overtemp_alert_n,
  output logic [1:0] pwm_out
);

  logic [7:0] config_byte_q, ot_lim_q [2], ot_mask_q, ot_status_q;
  logic [7:0] start_duty_q [2], max_duty_q [2], target_duty_q [2];
  logic [7:0] fan_step_config_q, start_temp_q [2], fan_channel_select_q;
  logic [7:0] rate_q, freq_sel_q, thermistor_offset_q;
  logic [7:0] temp_q [2], temp_low_q;
  logic [7:0] reg_rdata_q, duty_now [2];
  logic [1:0] alert_pend_q;
  logic overtemp_alert_n_q, conv_start_q, conv_ch_q;
  logic conv_local_q, local_d;
  logic [CONV_CNT_W-1:0] conv_cnt_q;
  logic conv_done_q;
  logic [7:0] new_temp;
  logic [2:0] new_frac;
  logic signed [12:0] adj;
  logic fault_now, status_rd, wr_mask;
  logic [PWM_DIV_W-1:0] div_cnt_q, div_max;
  logic [7:0] pwm_cnt_q, rate_cnt_q;
  logic period_end, ramp_tick;

  assign status_rd = reg_rd && (reg_addr == ADDR_OT_STATUS);
  assign wr_mask = reg_wr && (reg_addr == ADDR_OT_MASK);
  // next local select bit, so the registered pin tracks a config write at once
  assign local_d = (reg_wr && (reg_addr == ADDR_CONFIG)) ? reg_wdata[CFG_LOCAL2]
    : config_byte_q[CFG_LOCAL2];

  // register writes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      config_byte_q <= RST_CONFIG;
      ot_lim_q[0] <= RST_OT_LIM1;
      ot_lim_q[1] <= RST_OT_LIM2;
      ot_mask_q <= RST_ZERO;
      start_duty_q[0] <= RST_ZERO;
      start_duty_q[1] <= RST_ZERO;
      max_duty_q[0] <= RST_MAX_DUTY;
      max_duty_q[1] <= RST_MAX_DUTY;
      target_duty_q[0] <= RST_ZERO;
      target_duty_q[1] <= RST_ZERO;
      fan_step_config_q <= RST_ZERO;
      start_temp_q[0] <= RST_ZERO;
      start_temp_q[1] <= RST_ZERO;
      fan_channel_select_q <= RST_ZERO;
      rate_q <= RST_ZERO;
      freq_sel_q <= RST_ZERO;
      thermistor_offset_q <= RST_ZERO;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CONFIG: config_byte_q <= reg_wdata;
        ADDR_OT_LIM1: ot_lim_q[0] <= reg_wdata;
        ADDR_OT_LIM2: ot_lim_q[1] <= reg_wdata;
        ADDR_OT_MASK: ot_mask_q <= reg_wdata;
        ADDR_START_DUTY1: start_duty_q[0] <= reg_wdata;
        ADDR_START_DUTY2: start_duty_q[1] <= reg_wdata;
        ADDR_MAX_DUTY1: max_duty_q[0] <= reg_wdata;
        ADDR_MAX_DUTY2: max_duty_q[1] <= reg_wdata;
        ADDR_TARGET1: target_duty_q[0] <= reg_wdata;
        ADDR_TARGET2: target_duty_q[1] <= reg_wdata;
        ADDR_STEP_CFG: fan_step_config_q <= reg_wdata;
        ADDR_START_TEMP1: start_temp_q[0] <= reg_wdata;
        ADDR_START_TEMP2: start_temp_q[1] <= reg_wdata;
        ADDR_CHAN_SEL: fan_channel_select_q <= reg_wdata;
        ADDR_RATE: rate_q <= reg_wdata;
        ADDR_FREQ_SEL: freq_sel_q <= reg_wdata;
        ADDR_THERM_OFS: thermistor_offset_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // register reads, registered one cycle after the strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= RST_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_TEMP1: reg_rdata_q <= temp_q[0];
        ADDR_TEMP2: reg_rdata_q <= temp_q[1];
        ADDR_TEMP_LOW: reg_rdata_q <= {temp_low_q[2:0], 5'h00};
        ADDR_CONFIG: reg_rdata_q <= config_byte_q;
        ADDR_OT_LIM1: reg_rdata_q <= ot_lim_q[0];
        ADDR_OT_LIM2: reg_rdata_q <= ot_lim_q[1];
        ADDR_OT_STATUS: reg_rdata_q <= ot_status_q;
        ADDR_OT_MASK: reg_rdata_q <= ot_mask_q;
        ADDR_START_DUTY1: reg_rdata_q <= start_duty_q[0];
        ADDR_START_DUTY2: reg_rdata_q <= start_duty_q[1];
        ADDR_MAX_DUTY1: reg_rdata_q <= max_duty_q[0];
        ADDR_MAX_DUTY2: reg_rdata_q <= max_duty_q[1];
        ADDR_TARGET1: reg_rdata_q <= target_duty_q[0];
        ADDR_TARGET2: reg_rdata_q <= target_duty_q[1];
        ADDR_STEP_CFG: reg_rdata_q <= fan_step_config_q;
        ADDR_START_TEMP1: reg_rdata_q <= start_temp_q[0];
        ADDR_START_TEMP2: reg_rdata_q <= start_temp_q[1];
        ADDR_CHAN_SEL: reg_rdata_q <= fan_channel_select_q;
        ADDR_RATE: reg_rdata_q <= rate_q;
        ADDR_FREQ_SEL: reg_rdata_q <= freq_sel_q;
        ADDR_DUTY_NOW1: reg_rdata_q <= duty_now[0];
        ADDR_DUTY_NOW2: reg_rdata_q <= duty_now[1];
        ADDR_THERM_OFS: reg_rdata_q <= thermistor_offset_q;
        default: reg_rdata_q <= RST_ZERO;
      endcase
    end
  end

  // conversion sequencer; both channels always measured
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      conv_cnt_q <= '0;
      conv_ch_q <= 1'b0;
      conv_local_q <= 1'b0;
      conv_start_q <= 1'b0;
      conv_done_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      conv_done_q <= 1'b0;
      if (conv_cnt_q == CONV_CNT_W'(CONV_CNT - 1)) begin
        conv_cnt_q <= '0;
        conv_ch_q <= ~conv_ch_q;
        conv_local_q <= ~conv_ch_q & local_d;
        conv_start_q <= 1'b1;
        conv_done_q <= 1'b1;
      end else begin
        conv_cnt_q <= conv_cnt_q + CONV_CNT_W'(1);
        conv_local_q <= conv_ch_q & local_d;
      end
    end
  end

  // thermistor channels take the signed offset in whole degrees, eight counts each
  always_comb begin
    adj = 13'(adc_result);
    if (!(conv_ch_q && config_byte_q[CFG_LOCAL2])) begin
      adj = 13'(adc_result) + 13'(signed'({thermistor_offset_q, 3'h0}));
    end
    new_temp = adj[10:3];
    new_frac = adj[2:0];
    if (adj[12] && thermistor_offset_q[7]) begin
      new_temp = RST_ZERO;
      new_frac = 3'h0;
    end
  end

  // result sampled at the end of each channel period
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      temp_q[0] <= RST_ZERO;
      temp_q[1] <= RST_ZERO;
      temp_low_q <= RST_ZERO;
    end else if (conv_cnt_q == CONV_CNT_W'(CONV_CNT - 1)) begin
      temp_q[conv_ch_q] <= new_temp;
      if (conv_ch_q && config_byte_q[CFG_LOCAL2]) begin
        temp_low_q <= {5'h00, new_frac};
      end
    end
  end

  assign fault_now = (conv_cnt_q == CONV_CNT_W'(CONV_CNT - 1))
    && (new_temp > ot_lim_q[conv_ch_q]);

  // set wins over the clearing read so a fault is never lost
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ot_status_q <= RST_ZERO;
      alert_pend_q <= 2'h0;
      overtemp_alert_n_q <= 1'b1;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (fault_now && (conv_ch_q == 1'(c))) begin
          ot_status_q[STAT_CH1 - c] <= 1'b1;
          alert_pend_q[c] <= ~ot_mask_q[STAT_CH1 - c];
        end else if (status_rd) begin
          ot_status_q[STAT_CH1 - c] <= 1'b0;
          alert_pend_q[c] <= 1'b0;
        end else if (wr_mask && reg_wdata[STAT_CH1 - c]) begin
          alert_pend_q[c] <= 1'b0;
        end
      end
      overtemp_alert_n_q <= ~|(alert_pend_q & ~{ot_mask_q[STAT_CH2], ot_mask_q[STAT_CH1]});
    end
  end

  // shared pwm timebase
  assign div_max = (freq_sel_q[2:0] == 3'h0) ? PWM_DIV_W'(PWM_DIV_LOW - 1)
    : tfp_div_lookup(freq_sel_q[2:0]);
  assign period_end = (div_cnt_q == div_max) && (pwm_cnt_q == PWM_LAST);
  assign ramp_tick = period_end && (rate_cnt_q == rate_q);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_q <= '0;
      pwm_cnt_q <= RST_ZERO;
      rate_cnt_q <= RST_ZERO;
    end else begin
      if (div_cnt_q >= div_max) begin
        div_cnt_q <= '0;
        pwm_cnt_q <= (pwm_cnt_q >= PWM_LAST) ? RST_ZERO : pwm_cnt_q + 8'h01;
      end else begin
        div_cnt_q <= div_cnt_q + PWM_DIV_W'(1);
      end
      if (period_end) begin
        rate_cnt_q <= ramp_tick ? RST_ZERO : rate_cnt_q + 8'h01;
      end
    end
  end

  // per-output duty engine
  for (genvar i = 0; i < 2; i++) begin : g_fan
    logic [1:0] sel;
    logic [7:0] t_now, fan_start_temperature, hyst, excess, calc, below, man;
    logic [12:0] sum;
    logic [8:0] peak_lim;
    logic src_ch;
    logic [7:0] target_q, peak_q, duty_q;
    logic active_q, pwm_q;
    logic [SPIN_CNT_W-1:0] spin_cnt_q;
    tfp_fan_state_t state_q;

    assign sel = fan_channel_select_q[5 - 2 * i -: 2];
    assign src_ch = (sel == SEL_CH2) ? 1'b1
      : (sel == SEL_CH1) ? 1'b0 : (temp_q[1] > temp_q[0]);
    assign t_now = temp_q[src_ch];
    assign fan_start_temperature = start_temp_q[src_ch];
    assign hyst = fan_step_config_q[STEP_HYST] ? HYST_LARGE : HYST_SMALL;
    assign peak_lim = {1'b0, t_now} + {1'b0, PEAK_DROP};
    assign man = (target_duty_q[i] > DUTY_FULL) ? DUTY_FULL : target_duty_q[i];
    assign below = config_byte_q[CFG_MIN_DUTY] ? start_duty_q[i] : RST_ZERO;

    always_comb begin
      // inside the hysteresis band the excess would wrap to a huge value
      excess = (t_now > fan_start_temperature) ? t_now - fan_start_temperature : RST_ZERO;
      if (fan_step_config_q[STEP_TSTEP]) begin
        excess = {1'b0, excess[7:1]};
      end
      sum = 13'(start_duty_q[i]) + 13'(excess) * 13'(fan_step_config_q[3:0]);
      calc = (sum > 13'(max_duty_q[i])) ? max_duty_q[i] : sum[7:0];
      if (calc > DUTY_FULL) begin
        calc = DUTY_FULL;
      end
      calc[0] = 1'b0;
    end

    // target tracks conversions with peak hold and hysteresis
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        target_q <= RST_ZERO;
        peak_q <= RST_ZERO;
        active_q <= 1'b0;
      end else if (sel == SEL_MANUAL) begin
        target_q <= {man[7:1], 1'b0};
        active_q <= 1'b0;
      end else if (!active_q) begin
        if (t_now > fan_start_temperature) begin
          active_q <= 1'b1;
          peak_q <= t_now;
          target_q <= calc;
        end else begin
          target_q <= {below[7:1], 1'b0};
        end
      end else if (conv_done_q) begin
        if ({1'b0, t_now} + {1'b0, hyst} < {1'b0, fan_start_temperature}) begin
          active_q <= 1'b0;
          target_q <= {below[7:1], 1'b0};
        end else if (t_now > peak_q || peak_lim <= {1'b0, peak_q}) begin
          peak_q <= t_now;
          target_q <= calc;
        end
      end
    end

    // spin-up and rate limited approach to the target
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        state_q <= TFP_OFF;
        duty_q <= RST_ZERO;
        spin_cnt_q <= '0;
      end else begin
        unique case (state_q)
          TFP_OFF: begin
            spin_cnt_q <= '0;
            if (target_q != RST_ZERO) begin
              if (config_byte_q[CFG_SPIN_DIS]) begin
                duty_q <= target_q;
                state_q <= TFP_RUN;
              end else begin
                state_q <= TFP_SPIN;
              end
            end
          end
          TFP_SPIN: begin
            if (spin_cnt_q == SPIN_CNT_W'(SPIN_CNT - 1)) begin
              duty_q <= target_q;
              state_q <= TFP_RUN;
            end else begin
              spin_cnt_q <= spin_cnt_q + SPIN_CNT_W'(1);
            end
          end
          TFP_RUN: begin
            if (duty_q == RST_ZERO && target_q == RST_ZERO) begin
              state_q <= TFP_OFF;
            end else if (ramp_tick && duty_q < target_q) begin
              duty_q <= duty_q + DUTY_STEP;
            end else if (ramp_tick && duty_q > target_q) begin
              duty_q <= duty_q - DUTY_STEP;
            end
          end
          default: state_q <= TFP_OFF;
        endcase
      end
    end

    // spin-up forces full on before polarity is applied
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        pwm_q <= 1'b0;
      end else begin
        pwm_q <= ((state_q == TFP_SPIN) || (pwm_cnt_q < duty_q))
          ^ config_byte_q[CFG_INVERT];
      end
    end

    assign duty_now[i] = duty_q;
    assign pwm_out[i] = pwm_q;
  end

  assign reg_rdata = reg_rdata_q;
  assign conv_start = conv_start_q;
  assign conv_channel = conv_ch_q;
  assign conv_local = conv_local_q;
  assign overtemp_alert_n = overtemp_alert_n_q;

endmodule

`default_nettype wire

// >>> tb/tfp_fan_ctrl_assertions.sv
// port assertions for the fan pwm controller
`timescale 1ns/1ps
`default_nettype none
module tfp_fan_ctrl_assertions
  import tfp_pkg::*;
#(
  parameter int unsigned CONV_CNT = CONV_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic signed [11:0] adc_result,
  input wire logic conv_start,
  input wire logic conv_channel,
  input wire logic conv_local,
  input wire logic overtemp_alert_n,
  input wire logic [1:0] pwm_out
);
  logic [31:0] gap_q;
  logic seen_q;
  logic cfg5_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // first period after release is not timed, its start is not visible
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gap_q <= 32'h0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= conv_start ? 32'h0 : gap_q + 32'h1;
      seen_q <= seen_q | conv_start;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg5_q <= RST_CONFIG[CFG_LOCAL2];
    end else if (reg_wr && reg_addr == ADDR_CONFIG) begin
      cfg5_q <= reg_wdata[CFG_LOCAL2];
    end
  end
  sequence s_stat_rd;
    reg_rd && reg_addr == ADDR_OT_STATUS;
  endsequence
  sequence s_no_conv;
    !conv_start [*4];
  endsequence
  chk_conv_toggle: assert property ($changed(conv_channel) == conv_start)
    else $error("channel change without conversion pulse");
  chk_conv_spacing: assert property (conv_start && seen_q |-> gap_q == CONV_CNT - 1)
    else $error("conversion period length wrong");
  chk_local_select: assert property (conv_local == (conv_channel & cfg5_q))
    else $error("local sensor select wrong");
  chk_status_top: assert property (s_stat_rd |=> reg_rdata[5:0] == 6'h00)
    else $error("status low bits not zero");
  // a fault sampled near the read may legally set the alert again
  chk_alert_read_clear: assert property (!$past(conv_start) && !$past(conv_start, 2)
    && !$past(conv_start, 3) ##0 s_stat_rd ##0 s_no_conv |-> overtemp_alert_n)
    else $error("alert not cleared by status read");
  chk_alert_mask: assert property (reg_wr && reg_addr == ADDR_OT_MASK
    && reg_wdata[7:6] == 2'b11 |-> ##3 overtemp_alert_n [*3])
    else $error("alert not cleared by mask");
  chk_alert_cause: assert property ($fell(overtemp_alert_n) |-> $past(conv_start)
    || $past(conv_start, 2) || $past(conv_start, 3))
    else $error("alert asserted without conversion");
  chk_duty_even: assert property (reg_rd && (reg_addr == ADDR_DUTY_NOW1
    || reg_addr == ADDR_DUTY_NOW2) |=> !reg_rdata[0] && reg_rdata <= DUTY_FULL)
    else $error("duty odd or above full scale");
endmodule
bind tfp_fan_ctrl tfp_fan_ctrl_assertions #(.CONV_CNT(CONV_CNT)) u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_result(adc_result),
  .conv_start(conv_start), .conv_channel(conv_channel), .conv_local(conv_local),
  .overtemp_alert_n(overtemp_alert_n), .pwm_out(pwm_out));
`default_nettype wire

// >>> tb/tfp_fan_model.sv
// cooling fan model measuring drive time of one pwm output
`timescale 1ns/1ps
`default_nettype none
module tfp_fan_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic pwm_pin,
  input wire logic low_side,
  output logic [31:0] on_len
);
  logic [31:0] run_q;
  logic drive;
  // low-side switch or fan input conducts on the inverted sense
  assign drive = pwm_pin ^ low_side;
  // keeps only whole runs, so any selected rate is measured
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 32'h0;
      on_len <= 32'h0;
    end else if (drive) begin
      run_q <= run_q + 32'h1;
    end else begin
      run_q <= 32'h0;
      if (run_q != 32'h0) begin
        on_len <= run_q;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/test_tfp_fan_ctrl.sv
// self-checking bench for the fan pwm controller
`timescale 1ns/1ps
`default_nettype none
module test_tfp_fan_ctrl
  import tfp_pkg::*;
;
  localparam int unsigned CONV = 64;
  localparam int unsigned SPIN = 200;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic signed [11:0] adc_result = 12'h000;
  logic signed [11:0] ch1_val = 12'h000;
  logic signed [11:0] ch2_val = 12'h000;
  logic conv_start;
  logic conv_channel;
  logic conv_local;
  logic overtemp_alert_n;
  logic [1:0] pwm_out;
  logic low_side = 1'b0;
  logic [31:0] on_len;
  logic [7:0] rv;
  int num_errors = 0;
  int cmp_count = 0;

  always #2 clk_sys = ~clk_sys;
  // converter hands over the value of the channel being measured
  always @(posedge clk_sys) adc_result <= conv_channel ? ch2_val : ch1_val;

  tfp_fan_ctrl #(.CONV_CNT(CONV), .SPIN_CNT(SPIN), .PWM_DIV_LOW(1)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_result(adc_result),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_local(conv_local),
    .overtemp_alert_n(overtemp_alert_n), .pwm_out(pwm_out));
  tfp_fan_model u_fan (.clk_sys(clk_sys), .reset_n(reset_n), .pwm_pin(pwm_out[0]),
    .low_side(low_side), .on_len(on_len));

  task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    ch1_val <= 12'h000;
    ch2_val <= 12'h000;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask
  // bounded wait for a number of conversion pulses
  task automatic wait_conv(input int n);
    int got;
    got = 0;
    for (int i = 0; i < n * (CONV + 4) && got < n; i++) begin
      tick(1);
      if (conv_start === 1'b1) got++;
    end
    if (got < n) begin
      num_errors++;
      test_done();
    end
  endtask
  task automatic t_regs();
    logic [7:0] ad [9];
    logic [7:0] ex [9];
    ad = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0B, 8'h11, 8'h1F};
    ex = '{8'h18, 8'h6E, 8'h50, 8'h00, 8'h00, 8'hF0, 8'h00, 8'h00, 8'h00};
    do_reset();
    tick(2);
    check_eq(pwm_out, 2'b11);
    for (int i = 0; i < 9; i++) begin
      rd(ad[i]);
      check_eq(rv, ex[i]);
    end
  endtask
  task automatic t_manual();
    do_reset();
    wr(8'h02, 8'h1C);
    wr(8'h09, 8'h20);
    wr(8'h0B, 8'hFF);
    tick(4);
    rd(8'h14);
    check_eq(rv, 8'hF0);
    rd(8'h15);
    check_eq(rv, 8'h00);
  endtask
  task automatic t_spin();
    int bad;
    int n;
    bad = 0;
    n = 0;
    do_reset();
    wr(8'h0B, 8'h40);
    tick(3);
    for (int i = 0; i < SPIN - 10; i++) begin
      if (pwm_out[0] !== 1'b0) bad++;
      tick(1);
    end
    check_eq(bad, 0);
    tick(20);
    rd(8'h14);
    check_eq(rv, 8'h40);
    // one step of two per pwm period of 240 clocks, reads every 2 clocks
    wr(8'h0B, 8'h44);
    for (int i = 0; i < 1000 && rv != 8'h44; i++) begin
      rd(8'h14);
      if (rv == 8'h42) n++;
    end
    check_eq(n, 240 / 2);
    check_eq(rv, 8'h44);
    if (rv !== 8'h44) test_done();
  endtask
  // hold after a small drop, recompute after five, hysteresis below start
  task automatic t_peak();
    logic [7:0] tv [4];
    logic [7:0] ex [4];
    tv = '{8'h23, 8'h20, 8'h1C, 8'h1A};
    ex = '{8'h1E, 8'h10, 8'h10, 8'h00};
    do_reset();
    wr(8'h02, 8'h14);
    wr(8'h0D, 8'h03);
    wr(8'h0F, 8'h20);
    wr(8'h07, 8'h10);
    ch1_val <= {1'b0, 8'h25, 3'h0};
    wait_conv(3);
    wr(8'h11, 8'h10);
    for (int i = 0; i < 4; i++) begin
      ch1_val <= {1'b0, tv[i], 3'h0};
      wait_conv(40);
      rd(8'h14);
      check_eq(rv, ex[i]);
    end
  endtask
  task automatic t_ot();
    do_reset();
    wr(8'h02, 8'h38);
    wr(8'h17, 8'hF6);
    ch1_val <= 12'h028;
    ch2_val <= 12'h2AB;
    wait_conv(3);
    tick(3);
    check_eq(overtemp_alert_n, 1'b0);
    rd(8'h00);
    check_eq(rv, 8'h00);
    rd(8'h01);
    check_eq(rv, 8'h55);
    rd(8'h1E);
    check_eq(rv, 8'h60);
    rd(8'h05);
    check_eq(rv, 8'h40);
    tick(3);
    check_eq(overtemp_alert_n, 1'b1);
    wait_conv(2);
    tick(3);
    check_eq(overtemp_alert_n, 1'b0);
    wr(8'h06, 8'hC0);
    tick(4);
    check_eq(overtemp_alert_n, 1'b1);
    rd(8'h05);
    wait_conv(2);
    tick(3);
    check_eq(overtemp_alert_n, 1'b1);
    rd(8'h05);
    check_eq(rv, 8'h40);
  endtask
  task automatic t_auto();
    logic [7:0] tp [6];
    logic [7:0] sc [6];
    logic [7:0] cf [6];
    logic [7:0] mx [6];
    logic [7:0] ex [6];
    logic [7:0] o;
    tp = '{8'h25, 8'h26, 8'h40, 8'h10, 8'h10, 8'h25};
    sc = '{8'h03, 8'h43, 8'h03, 8'h03, 8'h03, 8'h03};
    cf = '{8'h1C, 8'h1C, 8'h1C, 8'h1C, 8'h14, 8'h1C};
    mx = '{8'hF0, 8'hF0, 8'h14, 8'hF0, 8'hF0, 8'hF0};
    ex = '{8'h1E, 8'h18, 8'h14, 8'h10, 8'h00, 8'h1E};
    for (int i = 0; i < 6; i++) begin
      o = (i == 5) ? 8'h01 : 8'h00;
      do_reset();
      wr(8'h02, cf[i]);
      wr(8'h0D, sc[i]);
      wr(8'h0F, 8'h20);
      wr(8'h10, 8'h80);
      wr(8'h07 + o, 8'h10);
      wr(8'h09 + o, mx[i]);
      // select only once converted, so the fan starts from off and jumps
      ch1_val <= {1'b0, tp[i], 3'h0};
      wait_conv(3);
      wr(8'h11, o[0] ? 8'h04 : 8'h10);
      tick(4);
      rd(8'h14 + o);
      check_eq(rv, ex[i]);
    end
  endtask
  // half-scale duty would hide a wrong sense, so 80 of 240 is used
  task automatic t_pwm();
    logic [2:0] sel [2];
    logic [7:0] cf [2];
    int stp [2];
    sel = '{3'h7, 3'h6};
    cf = '{8'h04, 8'h14};
    stp = '{31, 60};
    for (int i = 0; i < 2; i++) begin
      do_reset();
      low_side <= cf[i][CFG_INVERT];
      wr(8'h02, cf[i]);
      wr(8'h13, {5'h00, sel[i]});
      wr(8'h0B, 8'h50);
      tick(2 * 240 * stp[i] + 20);
      check_eq(on_len, 80 * stp[i]);
    end
  endtask

  initial begin
    do_reset();
    t_regs();
    t_manual();
    t_spin();
    t_ot();
    t_auto();
    t_peak();
    t_pwm();
    test_done();
  end
endmodule
`default_nettype wire
